// ===== pkg/rfs_regs.svh
// constants for the resonant fault supervisor
// assumes comparator flags arrive as clean levels synchronous to CLOCK
// Behaviour
// RQ1: feedback sense under target: slowly raise power offset.
// RQ2: negative load transient: lower the added power offset.
// RQ3: feedback drop: immediately raise capacitor swing, no waiting.
// RQ4: at low-power minimum energy and duty, feedback over burst level: burst.
// RQ5: in burst, feedback falls below burst threshold: start burst-on cycle.
// RQ6: supply undervoltage: stop, recharge from HV pin, pull boost low.
// RQ7: restart after supply uv only when both supplies exceed start.
// RQ8: high-side gate off while boot supply below reset threshold.
// RQ9: no switching until boost sense exceeds its start threshold.
// RQ10: boost undervoltage stops switching; resume above start threshold.
// RQ11: output overvoltage five consecutive cycles: latched fault, PFC off.
// RQ12: one converter alternates output and boost sampling.
// RQ13: current sense near zero: turn off conducting switch.
// RQ14: capacitive-mode avoidance never latches or stops converter.
// RQ15: overcurrent: turn off current switch, keep switching.
// RQ16: overcurrent five consecutive cycles: stop, protect, PFC off.
// RQ17: latched protection persists without switching until mains removed.
// RQ18: in latched or restart protection keep core supply at start level.
// RQ19: overpower latch or safe restart taken from external setting.
// RQ20: swing over overpower limit runs counter; past delay, protect.
// RQ21: overtemperature: latched protection and PFC disabled.
// RQ22: consecutive-cycle counters clear on any cycle without exceedance.
// RQ23: latched fault cleared only by power-on reset.
`ifndef RFS_REGS_SVH
`define RFS_REGS_SVH
`define RFS_CLK_MHZ        100
`define RFS_FAULT_CYCLES   5
`define RFS_FB_TARGET_MV   1020
`define RFS_BURST_UA       106
`define RFS_OPP_SHORT_MS   50
`define RFS_OPP_LONG_MS    200
`define RFS_RESTART_MS     1000
`define RFS_OFFSET_STEP_US 10
`define RFS_OFFSET_RST     8'h00
`define RFS_SWING_STEP     8'h10
`endif

// ===== pkg/rfs_pkg.sv
// types shared by the supervisor files
// assumes nothing beyond the constants header
package rfs_pkg;
    typedef enum logic [2:0] {
        ST_CHARGE,
        ST_WAIT_BOOST,
        ST_RUN,
        ST_RESTART,
        ST_LATCHED
    } rfs_state_t;

    typedef enum logic [1:0] {
        PM_HIGH,
        PM_LOW,
        PM_BURST
    } rfs_pmode_t;
endpackage

// ===== rtl/rfs_fault_count.sv
// consecutive-cycle fault counter with sticky trip
// assumes cycle_end is a one-cycle pulse per switching cycle
`include "rfs_regs.svh"
module rfs_fault_count #(
    parameter int LIMIT = `RFS_FAULT_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic cycle_end,
    input  wire logic exceeded,
    output logic      trip
);
    logic [3:0] count;
    logic [3:0] next_count;
    logic       next_trip;

    always_comb begin
        next_count = count;
        next_trip  = trip;
        if (cycle_end) begin
            if (exceeded) begin
                if (count < 4'(LIMIT))
                    next_count = count + 4'h1;
            end else begin
                next_count = 4'h0; // RQ22
            end
            if (exceeded && count == 4'(LIMIT - 1))
                next_trip = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 4'h0;
            trip  <= 1'b0;
        end else begin
            count <= next_count;
            trip  <= next_trip;
        end
    end

    trip_after_limit_a: assert property ( // RQ11 RQ16
        @(posedge clk) disable iff (rst)
        (cycle_end && exceeded && count == 4'(LIMIT - 1)) |=> trip)
        else $error("fault counter did not trip at limit");
    clear_on_quiet_a: assert property (@(posedge clk) disable iff (rst) // RQ22
        (cycle_end && !exceeded) |=> count == 4'h0)
        else $error("fault counter not cleared on quiet cycle");
endmodule // rfs_fault_count

// ===== rtl/rfs_divider.sv
// divider producing a one-cycle tick every DIV clocks
// assumes a single clock domain
module rfs_divider #(
    parameter int DIV = 1000
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      tick
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic        next_tick;

    always_comb begin
        next_tick = (cnt == 32'(DIV - 1));
        next_cnt  = next_tick ? 32'h0 : cnt + 32'h1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt  <= 32'h0;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule // rfs_divider

// ===== rtl/rfs_supervisor.sv
// top of the resonant fault supervisor
// assumes comparator inputs synchronous to CLOCK, gate requests from the
// switching core, and CYCLE_END one pulse per switching cycle
`include "rfs_regs.svh"
module rfs_supervisor #(
    parameter int OPP_SHORT_CYC = `RFS_OPP_SHORT_MS * 1000 * `RFS_CLK_MHZ,
    parameter int OPP_LONG_CYC  = `RFS_OPP_LONG_MS * 1000 * `RFS_CLK_MHZ,
    parameter int RESTART_CYC   = `RFS_RESTART_MS * 1000 * `RFS_CLK_MHZ,
    parameter int STEP_CYC      = `RFS_OFFSET_STEP_US * `RFS_CLK_MHZ
) (
    input  wire logic       CLOCK,
    input  wire logic       RST,
    input  wire logic       CYCLE_END,
    input  wire logic       HS_REQ,
    input  wire logic       LS_REQ,
    input  wire logic       FB_BELOW_TARGET,
    input  wire logic       FB_ABOVE_BURST,
    input  wire logic       LOAD_DROP,
    input  wire logic       LP_AT_MIN,
    input  wire logic       LOW_POWER_REQ,
    input  wire logic       CORE_SUPPLY_UV,
    input  wire logic       CORE_SUPPLY_START,
    input  wire logic       REG_SUPPLY_UV,
    input  wire logic       REG_SUPPLY_START,
    input  wire logic       BOOT_SUPPLY_LOW,
    input  wire logic       BOOST_START,
    input  wire logic       BOOST_UV,
    input  wire logic       OUTPUT_OV,
    input  wire logic       CUR_NEAR_ZERO,
    input  wire logic       CUR_OVER,
    input  wire logic       SWING_OVER_OPP,
    input  wire logic       OVER_TEMP,
    input  wire logic       OPP_LATCH_SEL,
    input  wire logic       OPP_LONG_SEL,
    input  wire logic       OPP_DISABLE,
    output logic            HIGHSIDE_GATE,
    output logic            LOWSIDE_GATE,
    output logic            SWITCH_EN,
    output logic            HV_CHARGE,
    output logic            BOOST_PULL_LOW,
    output logic            ADC_SEL_OUT,
    output logic [7:0]      POWER_OFFSET,
    output logic            SWING_BOOST,
    output logic [1:0]      POWER_MODE,
    output logic            BURST_ON_START,
    output logic            LATCHED
);
    // ****************************************************************
    // consecutive-cycle counters and offset stepping
    // ****************************************************************
    logic ovp_sample;
    logic ovp_trip;
    logic ocp_trip;
    logic step_tick;
    logic ov_seen;
    logic ov_hit;
    logic oc_seen;

    // ov flag only meaningful on the cycles the shared converter watches it
    assign ov_hit = ov_seen;

    rfs_fault_count #(.LIMIT(`RFS_FAULT_CYCLES)) u_ovp (
        .clk       (CLOCK),
        .rst       (RST),
        .cycle_end (ovp_sample),
        .exceeded  (ov_hit),
        .trip      (ovp_trip)
    );

    rfs_fault_count #(.LIMIT(`RFS_FAULT_CYCLES)) u_ocp (
        .clk       (CLOCK),
        .rst       (RST),
        .cycle_end (CYCLE_END),
        .exceeded  (oc_seen),
        .trip      (ocp_trip)
    );

    rfs_divider #(.DIV(STEP_CYC)) u_step (
        .clk  (CLOCK),
        .rst  (RST),
        .tick (step_tick)
    );

    // ****************************************************************
    // supervisory state
    // ****************************************************************
    rfs_pkg::rfs_state_t state;
    rfs_pkg::rfs_state_t next_state;
    rfs_pkg::rfs_pmode_t pmode;
    rfs_pkg::rfs_pmode_t next_pmode;
    logic [31:0] opp_cnt;
    logic [31:0] next_opp_cnt;
    logic [31:0] rst_cnt;
    logic [31:0] next_rst_cnt;
    logic        adc_out;
    logic        next_adc_out;
    logic        next_ov_seen;
    logic        next_oc_seen;
    logic        latched;
    logic        next_latched;
    logic        fb_above_d;
    logic [7:0]  offset;
    logic [7:0]  next_offset;
    logic        supply_uv;
    logic        opp_trip;
    logic        latch_cause;
    logic        running;

    assign supply_uv   = CORE_SUPPLY_UV || REG_SUPPLY_UV;
    assign opp_trip    = !OPP_DISABLE && SWING_OVER_OPP
        && (opp_cnt >= (OPP_LONG_SEL ? 32'(OPP_LONG_CYC)
                                     : 32'(OPP_SHORT_CYC)));    // RQ20
    assign latch_cause = ovp_trip || ocp_trip || OVER_TEMP // RQ11 RQ16 RQ21
        || (opp_trip && OPP_LATCH_SEL);                         // RQ19
    assign running     = (state == rfs_pkg::ST_RUN);
    assign ovp_sample  = CYCLE_END && adc_out;                  // RQ12

    always_comb begin
        next_state   = state;
        next_rst_cnt = 32'h0;
        next_latched = latched || latch_cause;                  // RQ23
        unique case (state)
            rfs_pkg::ST_CHARGE:
                if (CORE_SUPPLY_START && REG_SUPPLY_START)      // RQ7
                    next_state = rfs_pkg::ST_WAIT_BOOST;
            rfs_pkg::ST_WAIT_BOOST:
                if (supply_uv)
                    next_state = rfs_pkg::ST_CHARGE;
                else if (BOOST_START)                           // RQ9 RQ10
                    next_state = rfs_pkg::ST_RUN;
            rfs_pkg::ST_RUN:
                if (supply_uv)                                  // RQ6
                    next_state = rfs_pkg::ST_CHARGE;
                else if (BOOST_UV)                              // RQ10
                    next_state = rfs_pkg::ST_WAIT_BOOST;
                else if (opp_trip && !OPP_LATCH_SEL)            // RQ19
                    next_state = rfs_pkg::ST_RESTART;
            rfs_pkg::ST_RESTART: begin
                next_rst_cnt = rst_cnt + 32'h1;
                if (rst_cnt >= 32'(RESTART_CYC - 1))
                    next_state = rfs_pkg::ST_CHARGE;
            end
            rfs_pkg::ST_LATCHED: ;                              // RQ17
        endcase
        if (next_latched)
            next_state = rfs_pkg::ST_LATCHED;                   // RQ17
    end

    always_comb begin
        next_adc_out = CYCLE_END ? !adc_out : adc_out;          // RQ12
        next_ov_seen = CYCLE_END ? 1'b0 : (ov_seen || OUTPUT_OV);
        next_oc_seen = CYCLE_END ? 1'b0 : (oc_seen || CUR_OVER);
        if (adc_out && !CYCLE_END)
            next_ov_seen = ov_seen || OUTPUT_OV;
        next_opp_cnt = (running && SWING_OVER_OPP) ? opp_cnt + 32'h1
                                                   : 32'h0;     // RQ20
        next_offset = offset;
        if (step_tick && running) begin
            if (FB_BELOW_TARGET && offset != 8'hFF)
                next_offset = offset + 8'h01;                   // RQ1
            else if (LOAD_DROP && offset != 8'h00)
                next_offset = offset - 8'h01;                   // RQ2
        end
        next_pmode = pmode;
        if (!running)
            next_pmode = rfs_pkg::PM_HIGH;
        else unique case (pmode)
            rfs_pkg::PM_HIGH:
                if (LOW_POWER_REQ)
                    next_pmode = rfs_pkg::PM_LOW;
            rfs_pkg::PM_LOW:
                if (LP_AT_MIN && FB_ABOVE_BURST)                // RQ4
                    next_pmode = rfs_pkg::PM_BURST;
                else if (!LOW_POWER_REQ)
                    next_pmode = rfs_pkg::PM_HIGH;
            rfs_pkg::PM_BURST:
                if (!LOW_POWER_REQ)
                    next_pmode = rfs_pkg::PM_HIGH;
        endcase
    end

    // ****************************************************************
    // registers and outputs
    // ****************************************************************
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state          <= rfs_pkg::ST_CHARGE;
            pmode          <= rfs_pkg::PM_HIGH;
            opp_cnt        <= 32'h0;
            rst_cnt        <= 32'h0;
            adc_out        <= 1'b0;
            ov_seen        <= 1'b0;
            oc_seen        <= 1'b0;
            latched        <= 1'b0;
            fb_above_d     <= 1'b0;
            offset         <= `RFS_OFFSET_RST;
            HIGHSIDE_GATE  <= 1'b0;
            LOWSIDE_GATE   <= 1'b0;
            SWITCH_EN      <= 1'b0;
            HV_CHARGE      <= 1'b1;
            BOOST_PULL_LOW <= 1'b1;
            ADC_SEL_OUT    <= 1'b0;
            POWER_OFFSET   <= `RFS_OFFSET_RST;
            SWING_BOOST    <= 1'b0;
            POWER_MODE     <= 2'h0;
            BURST_ON_START <= 1'b0;
            LATCHED        <= 1'b0;
        end else begin
            state          <= next_state;
            pmode          <= next_pmode;
            opp_cnt        <= next_opp_cnt;
            rst_cnt        <= next_rst_cnt;
            adc_out        <= next_adc_out;
            ov_seen        <= next_ov_seen;
            oc_seen        <= next_oc_seen;
            latched        <= next_latched;
            fb_above_d     <= FB_ABOVE_BURST;
            offset         <= next_offset;
            // near-zero and overcurrent cut conduction; near-zero never stops, overcurrent stops after five cycles in a row
            HIGHSIDE_GATE  <= (next_state == rfs_pkg::ST_RUN) && HS_REQ
                && !BOOT_SUPPLY_LOW                             // RQ8
                && !CUR_NEAR_ZERO && !CUR_OVER; // RQ13 RQ14 RQ15
            LOWSIDE_GATE   <= (next_state == rfs_pkg::ST_RUN) && LS_REQ
                && !CUR_NEAR_ZERO && !CUR_OVER;                 // RQ13 RQ15
            SWITCH_EN      <= (next_state == rfs_pkg::ST_RUN);  // RQ16
            HV_CHARGE      <= (next_state != rfs_pkg::ST_RUN)
                && (next_state != rfs_pkg::ST_WAIT_BOOST
                    || supply_uv);                              // RQ6 RQ18
            // PFC also stays off through a safe restart
            BOOST_PULL_LOW <= (next_state == rfs_pkg::ST_CHARGE)
                || (next_state == rfs_pkg::ST_RESTART)          // RQ19
                || next_latched; // RQ6 RQ11 RQ16 RQ21
            ADC_SEL_OUT    <= next_adc_out;
            POWER_OFFSET   <= next_offset;
            SWING_BOOST    <= running && FB_BELOW_TARGET;       // RQ3
            POWER_MODE     <= next_pmode;
            BURST_ON_START <= (pmode == rfs_pkg::PM_BURST)
                && fb_above_d && !FB_ABOVE_BURST;               // RQ5
            LATCHED        <= next_latched;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // latched protection: switching stopped and the PFC held off
    sequence protect_s;
        LATCHED && !SWITCH_EN && BOOST_PULL_LOW;
    endsequence

    latch_holds_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ17
        LATCHED |=> LATCHED && !SWITCH_EN)
        else $error("latched fault released or switching");
    boot_low_hs_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ8
        BOOT_SUPPLY_LOW |=> !HIGHSIDE_GATE)
        else $error("high side on with low boot supply");
    supply_uv_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ6
        (supply_uv && !latched && !latch_cause)
        |=> !SWITCH_EN && BOOST_PULL_LOW && HV_CHARGE)
        else $error("supply undervoltage not handled");
    latched_charge_a: assert property ( // RQ18
        @(posedge CLOCK) disable iff (RST)
        LATCHED |-> HV_CHARGE)
        else $error("core supply not held in protection");
    ovp_latch_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ11
        ovp_trip |=> LATCHED && BOOST_PULL_LOW)
        else $error("overvoltage did not latch");
    ocp_latch_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ16
        ocp_trip |=> protect_s)
        else $error("overcurrent did not latch");
    boost_start_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ9
        (state == rfs_pkg::ST_WAIT_BOOST && !BOOST_START) |=> !SWITCH_EN)
        else $error("switching before boost start");
    near_zero_cut_a: assert property ( // RQ13
        @(posedge CLOCK) disable iff (RST)
        CUR_NEAR_ZERO |=> !HIGHSIDE_GATE && !LOWSIDE_GATE)
        else $error("switch kept on near zero current");
    temp_latch_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ21
        OVER_TEMP |=> LATCHED && BOOST_PULL_LOW)
        else $error("overtemperature not latched");
    adc_alt_a: assert property (@(posedge CLOCK) disable iff (RST) // RQ12
        CYCLE_END |=> ADC_SEL_OUT != $past(ADC_SEL_OUT))
        else $error("converter did not alternate");
endmodule // rfs_supervisor

// ===== bench/rfs_stage_model.sv
// switching-core stand-in: gate requests and one cycle-end pulse per period
// assumes the supervisor samples everything on the rising clock edge
module rfs_stage_model #(
    parameter int PERIOD = 10
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      cycle_end,
    output logic      hs_req,
    output logic      ls_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // half-bridge request sequencer
    // ****************************************
    int cnt;
    // requests never stop; only the supervisor may hold the gates off
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            cycle_end <= 1'b0;
            hs_req <= 1'b0;
            ls_req <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            cycle_end <= (cnt == PERIOD - 2);
            hs_req <= (cnt < PERIOD / 2 - 1);
            ls_req <= (cnt >= PERIOD / 2) && (cnt < PERIOD - 1);
        end
    end
endmodule // rfs_stage_model

// ===== bench/rfs_supervisor_tb_top.sv
// self-checking bench for the resonant fault supervisor
// assumes short timer parameters: opp 20/40, restart 30, offset step 4
module rfs_supervisor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // stimulus, design and stage model
    // ****************************************
    localparam int PER = 10;
    logic CLOCK = 1'b0, RST = 1'b1, CYCLE_END, HS_REQ, LS_REQ;
    logic FB_BELOW_TARGET = 1'b0, FB_ABOVE_BURST = 1'b0, LOAD_DROP = 1'b0;
    logic LP_AT_MIN = 1'b0, LOW_POWER_REQ = 1'b0, CORE_SUPPLY_UV = 1'b0;
    logic CORE_SUPPLY_START = 1'b0, REG_SUPPLY_UV = 1'b0;
    logic REG_SUPPLY_START = 1'b0, BOOT_SUPPLY_LOW = 1'b0, BOOST_START = 1'b0;
    logic BOOST_UV = 1'b0, OUTPUT_OV = 1'b0, CUR_NEAR_ZERO = 1'b0;
    logic CUR_OVER = 1'b0, SWING_OVER_OPP = 1'b0, OVER_TEMP = 1'b0;
    logic OPP_LATCH_SEL = 1'b0, OPP_LONG_SEL = 1'b0, OPP_DISABLE = 1'b0;
    logic HIGHSIDE_GATE, LOWSIDE_GATE, SWITCH_EN, HV_CHARGE, BOOST_PULL_LOW;
    logic ADC_SEL_OUT, SWING_BOOST, BURST_ON_START, LATCHED;
    logic [7:0] POWER_OFFSET;
    logic [1:0] POWER_MODE;
    int miscompares = 0;
    int compares = 0;

    always #5 CLOCK = ~CLOCK;

    rfs_supervisor #(.OPP_SHORT_CYC(20), .OPP_LONG_CYC(40),
        .RESTART_CYC(30), .STEP_CYC(4)) i_rfs_supervisor (
        .CLOCK, .RST, .CYCLE_END, .HS_REQ, .LS_REQ, .FB_BELOW_TARGET,
        .FB_ABOVE_BURST, .LOAD_DROP, .LP_AT_MIN, .LOW_POWER_REQ,
        .CORE_SUPPLY_UV, .CORE_SUPPLY_START, .REG_SUPPLY_UV,
        .REG_SUPPLY_START, .BOOT_SUPPLY_LOW, .BOOST_START, .BOOST_UV,
        .OUTPUT_OV, .CUR_NEAR_ZERO, .CUR_OVER, .SWING_OVER_OPP, .OVER_TEMP,
        .OPP_LATCH_SEL, .OPP_LONG_SEL, .OPP_DISABLE, .HIGHSIDE_GATE,
        .LOWSIDE_GATE, .SWITCH_EN, .HV_CHARGE, .BOOST_PULL_LOW, .ADC_SEL_OUT,
        .POWER_OFFSET, .SWING_BOOST, .POWER_MODE, .BURST_ON_START, .LATCHED);

    rfs_stage_model #(.PERIOD(PER)) i_rfs_stage_model (.clk(CLOCK),
        .rst(RST), .cycle_end(CYCLE_END), .hs_req(HS_REQ), .ls_req(LS_REQ));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask

    task automatic ends(input int n);
        repeat (n) @(posedge CLOCK iff CYCLE_END === 1'b1);
    endtask

    // counts clocks with each gate on, as standing just before each edge
    task automatic gates(input int n, output int hs, output int ls);
        hs = 0;
        ls = 0;
        repeat (n) begin
            @(posedge CLOCK);
            hs += (HIGHSIDE_GATE === 1'b1);
            ls += (LOWSIDE_GATE === 1'b1);
        end
    endtask

    task automatic do_reset;
        RST <= 1'b1;
        CORE_SUPPLY_START <= 1'b0;
        REG_SUPPLY_START <= 1'b0;
        BOOST_START <= 1'b0;
        cyc(3);
        check(HV_CHARGE, 1'b1);
        check(BOOST_PULL_LOW, 1'b1);
        check(SWITCH_EN, 1'b0);
        check(LATCHED, 1'b0);
        check(POWER_OFFSET, 8'h00);
        RST <= 1'b0;
        cyc(1);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_start;
        CORE_SUPPLY_START <= 1'b1;
        cyc(5);
        check(SWITCH_EN, 1'b0);
        REG_SUPPLY_START <= 1'b1;
        cyc(5);
        check(SWITCH_EN, 1'b0);
        BOOST_START <= 1'b1;
        cyc(4);
        check(SWITCH_EN, 1'b1);
        check(BOOST_PULL_LOW, 1'b0);
        $display("test start done");
    endtask

    task automatic expect_latched;
        cyc(4 * PER);
        check(LATCHED, 1'b1);
        check(SWITCH_EN, 1'b0);
        check(BOOST_PULL_LOW, 1'b1);
        check(HV_CHARGE, 1'b1);
        do_reset();
        t_start();
    endtask

    task automatic t_gates;
        int hs;
        int ls;
        gates(3 * PER, hs, ls);
        check(8'(hs != 0), 8'h01);
        check(8'(ls != 0), 8'h01);
        BOOT_SUPPLY_LOW <= 1'b1;
        cyc(2);
        gates(3 * PER, hs, ls);
        check(8'(hs), 8'h00);
        check(8'(ls != 0), 8'h01);
        BOOT_SUPPLY_LOW <= 1'b0;
        CUR_NEAR_ZERO <= 1'b1;
        cyc(2);
        gates(3 * PER, hs, ls);
        check(8'(hs + ls), 8'h00);
        check(SWITCH_EN, 1'b1);
        check(LATCHED, 1'b0);
        CUR_NEAR_ZERO <= 1'b0;
        // short burst so the overcurrent count stays far below five
        CUR_OVER <= 1'b1;
        cyc(2);
        gates(12, hs, ls);
        check(8'(hs + ls), 8'h00);
        CUR_OVER <= 1'b0;
        check(SWITCH_EN, 1'b1);
        ends(2);
        $display("test gates done");
    endtask

    task automatic t_offset;
        logic [7:0] o;
        o = POWER_OFFSET;
        FB_BELOW_TARGET <= 1'b1;
        cyc(2);
        check(SWING_BOOST, 1'b1);
        cyc(38);
        check(8'((POWER_OFFSET - o) inside {[9:11]}), 8'h01);
        FB_BELOW_TARGET <= 1'b0;
        LOAD_DROP <= 1'b1;
        cyc(2);
        o = POWER_OFFSET;
        cyc(20);
        check(8'((o - POWER_OFFSET) inside {[4:6]}), 8'h01);
        LOAD_DROP <= 1'b0;
        $display("test offset done");
    endtask

    task automatic t_burst;
        LOW_POWER_REQ <= 1'b1;
        for (int i = 0; i < 100 && POWER_MODE !== 2'h1; i++) cyc(1);
        check(POWER_MODE, 2'h1);
        LP_AT_MIN <= 1'b1;
        FB_ABOVE_BURST <= 1'b1;
        for (int i = 0; i < 100 && POWER_MODE !== 2'h2; i++) cyc(1);
        check(POWER_MODE, 2'h2);
        FB_ABOVE_BURST <= 1'b0;
        for (int i = 0; i < 100 && BURST_ON_START !== 1'b1; i++) cyc(1);
        check(BURST_ON_START, 1'b1);
        LOW_POWER_REQ <= 1'b0;
        LP_AT_MIN <= 1'b0;
        cyc(50);
        $display("test burst done");
    endtask

    task automatic t_uv;
        BOOST_UV <= 1'b1;
        BOOST_START <= 1'b0;
        cyc(3);
        check(SWITCH_EN, 1'b0);
        BOOST_UV <= 1'b0;
        cyc(3);
        check(SWITCH_EN, 1'b0);
        BOOST_START <= 1'b1;
        cyc(4);
        check(SWITCH_EN, 1'b1);
        REG_SUPPLY_UV <= 1'b1;
        REG_SUPPLY_START <= 1'b0;
        cyc(3);
        check(SWITCH_EN, 1'b0);
        check(HV_CHARGE, 1'b1);
        check(BOOST_PULL_LOW, 1'b1);
        REG_SUPPLY_UV <= 1'b0;
        cyc(3);
        check(SWITCH_EN, 1'b0);
        REG_SUPPLY_START <= 1'b1;
        cyc(5);
        check(SWITCH_EN, 1'b1);
        $display("test undervoltage done");
    endtask

    task automatic t_opp;
        OPP_DISABLE <= 1'b1;
        SWING_OVER_OPP <= 1'b1;
        cyc(50);
        check(SWITCH_EN, 1'b1);
        SWING_OVER_OPP <= 1'b0;
        OPP_DISABLE <= 1'b0;
        cyc(2);
        OPP_LONG_SEL <= 1'b1;
        SWING_OVER_OPP <= 1'b1;
        cyc(30);
        check(SWITCH_EN, 1'b1);
        cyc(20);
        check(SWITCH_EN, 1'b0);
        check(LATCHED, 1'b0);
        check(HV_CHARGE, 1'b1);
        SWING_OVER_OPP <= 1'b0;
        cyc(45);
        check(SWITCH_EN, 1'b1);
        OPP_LONG_SEL <= 1'b0;
        OPP_LATCH_SEL <= 1'b1;
        SWING_OVER_OPP <= 1'b1;
        cyc(30);
        check(LATCHED, 1'b1);
        SWING_OVER_OPP <= 1'b0;
        OPP_LATCH_SEL <= 1'b0;
        expect_latched();
        $display("test overpower done");
    endtask

    task automatic t_ocp;
        CUR_OVER <= 1'b1;
        ends(4);
        CUR_OVER <= 1'b0;
        ends(2);
        check(LATCHED, 1'b0);
        CUR_OVER <= 1'b1;
        ends(4);
        cyc(2);
        check(LATCHED, 1'b0);
        ends(1);
        CUR_OVER <= 1'b0;
        cyc(3);
        check(LATCHED, 1'b1);
        expect_latched();
        $display("test overcurrent done");
    endtask

    task automatic t_ovp;
        logic a;
        a = ADC_SEL_OUT;
        ends(1);
        cyc(1);
        check(ADC_SEL_OUT, !a);
        OUTPUT_OV <= 1'b1;
        ends(8);
        cyc(2);
        check(LATCHED, 1'b0);
        ends(3);
        cyc(3);
        check(LATCHED, 1'b1);
        OUTPUT_OV <= 1'b0;
        expect_latched();
        $display("test overvoltage done");
    endtask

    task automatic t_otp;
        OVER_TEMP <= 1'b1;
        cyc(3);
        check(LATCHED, 1'b1);
        check(BOOST_PULL_LOW, 1'b1);
        OVER_TEMP <= 1'b0;
        expect_latched();
        $display("test overtemperature done");
    endtask

    // ****************************************
    // sequence and watchdog
    // ****************************************
    initial begin
        do_reset();
        t_start();
        t_gates();
        t_offset();
        t_burst();
        t_uv();
        t_opp();
        t_ocp();
        t_ovp();
        t_otp();
        test_done();
    end

    // the whole run needs about a thousand clocks; this is twenty times that
    initial begin
        #200us;
        miscompares++;
        $display("watchdog expired");
        test_done();
    end
endmodule // rfs_supervisor_tb_top
